/* hw/ccen_pkg.sv */
// Constants for the channel enable and polarity block
package ccen_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CCEN = 8'h20;
	localparam logic [7:0] ADDR_DIRSEL = 8'h40;
	localparam logic [7:0] ADDR_BRK = 8'h44;
	localparam logic [7:0] ADDR_IDLE = 8'h48;
	localparam logic [7:0] ADDR_CAPST = 8'h4c;
	// ----------------------------------------------------------------
	// Reset values and implemented bits
	// ----------------------------------------------------------------
	localparam logic [31:0] CCEN_RESET = 32'h0000_0000;
	localparam logic [31:0] CCEN_MASK = 32'h0033_3fff;
	localparam logic [11:0] DIRSEL_RESET = 12'h000;
	localparam logic [2:0] BRK_RESET = 3'h0;
	localparam logic [7:0] DT_RESET = 8'h00;
	localparam logic [5:0] IDLE_MAIN_RESET = 6'h00;
	localparam logic [2:0] IDLE_COMP_RESET = 3'h0;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int NUM_CH = 6;
	localparam int NUM_COMP = 3;
	localparam int OUT_EN_BIT [0:5] = '{0, 4, 8, 12, 16, 20};
	localparam int OUT_POL_BIT [0:5] = '{1, 5, 9, 13, 17, 21};
	localparam int COMP_EN_BIT [0:2] = '{2, 6, 10};
	localparam int COMP_POL_BIT [0:2] = '{3, 7, 11};
	localparam int DIRSEL_W = 2;
	localparam int MOE_BIT = 0;
	localparam int IDLE_OFF_BIT = 1;
	localparam int RUN_OFF_BIT = 2;
	localparam int DT_LSB = 8;
	localparam int DT_W = 8;
	localparam int IDLE_COMP_LSB = 8;
	localparam logic [1:0] DIR_OUTPUT = 2'h0;
endpackage

/* hw/cap_edge.sv */
// Input-mode edge selection and capture gating for one channel
`timescale 1ns/1ps
module cap_edge (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control
	input wire logic in_mode,
	input wire logic enable,
	input wire logic polarity,
	// Channel input and results
	input wire logic cap_in,
	output logic trig,
	output logic capture
);
	// ----------------------------------------------------------------
	// Edge detect on the polarity-corrected input
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			trig <= 1'b0;
		else
			trig <= cap_in ^ polarity;
	end

	// Edges while disabled are dropped, not held for later
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			capture <= 1'b0;
		else
			capture <= in_mode & enable & (cap_in ^ polarity) & ~trig;
	end

	property p_cap_gate;
		@(posedge clk) disable iff (!rstn)
		capture |-> $past(enable) && $past(in_mode);
	endproperty
	a_cap_gate: assert property (p_cap_gate) else $error("capture while disabled");

	property p_cap_edge;
		@(posedge clk) disable iff (!rstn)
		in_mode && enable && !trig && (cap_in ^ polarity) |=> capture && trig;
	endproperty
	a_cap_edge: assert property (p_cap_edge) else $error("selected edge not captured");
endmodule

/* hw/out_stage.sv */
// Output stage of one channel: enables, polarity, off states, dead time
`timescale 1ns/1ps
module out_stage (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Channel control
	input wire logic out_mode,
	input wire logic ref_wave,
	input wire logic out_en,
	input wire logic out_pol,
	input wire logic comp_en,
	input wire logic comp_pol,
	input wire logic idle_main,
	input wire logic idle_comp,
	// Shared break control
	input wire logic moe,
	input wire logic idle_off_sel,
	input wire logic run_off_sel,
	input wire logic [7:0] dead_time,
	// Pin side
	output logic main_out,
	output logic main_oe,
	output logic comp_out,
	output logic comp_oe
);
	logic prev_ref;
	logic [7:0] dt_cnt;
	logic dt_done;
	logic en;
	logic next_main, next_main_oe, next_comp, next_comp_oe;

	assign en = out_en & out_mode;
	// The cycle that sees a reference edge is never done, so no stale zero count lets a glitch through
	assign dt_done = (dt_cnt == 8'h00) && (ref_wave == prev_ref);

	// ----------------------------------------------------------------
	// Dead time counter, restarted on every reference edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prev_ref <= 1'b0;
			dt_cnt <= 8'h00;
		end
		else
		begin
			prev_ref <= ref_wave;
			if (ref_wave != prev_ref)
				dt_cnt <= dead_time;
			else if (!dt_done)
				dt_cnt <= dt_cnt - 8'h01;
		end
	end

	always_comb
	begin
		next_main = 1'b0;
		next_main_oe = 1'b0;
		next_comp = 1'b0;
		next_comp_oe = 1'b0;
		if (moe)
		begin
			if (en && comp_en)
			begin
				next_main = (ref_wave & dt_done) ^ out_pol;
				next_comp = (~ref_wave & dt_done) ^ comp_pol;
				next_main_oe = 1'b1;
				next_comp_oe = 1'b1;
			end
			else
			begin
				if (en)
				begin
					next_main = ref_wave ^ out_pol;
					next_main_oe = 1'b1;
				end
				else if (run_off_sel)
				begin
					next_main = out_pol;
					next_main_oe = comp_en;
				end
				if (comp_en)
				begin
					next_comp = ref_wave ^ comp_pol;
					next_comp_oe = 1'b1;
				end
				else if (run_off_sel)
				begin
					next_comp = comp_pol;
					next_comp_oe = en;
				end
			end
		end
		else if (en || comp_en)
		begin
			// Idle levels apply only when the off state is driven
			next_main = idle_off_sel ? idle_main : out_pol;
			next_comp = idle_off_sel ? idle_comp : comp_pol;
			next_main_oe = idle_off_sel;
			next_comp_oe = idle_off_sel;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			main_out <= 1'b0;
			main_oe <= 1'b0;
			comp_out <= 1'b0;
			comp_oe <= 1'b0;
		end
		else
		begin
			main_out <= next_main;
			main_oe <= next_main_oe;
			comp_out <= next_comp;
			comp_oe <= next_comp_oe;
		end
	end

	property p_main_follow;
		@(posedge clk) disable iff (!rstn)
		moe && en && !comp_en |=> main_oe && (main_out == ($past(ref_wave) ^ $past(out_pol)));
	endproperty
	a_main_follow: assert property (p_main_follow) else $error("main output not ref xor polarity");

	property p_comp_follow;
		@(posedge clk) disable iff (!rstn)
		moe && comp_en && !en |=> comp_oe && (comp_out == ($past(ref_wave) ^ $past(comp_pol)));
	endproperty
	a_comp_follow: assert property (p_comp_follow) else $error("comp output not ref xor polarity");

	property p_main_off;
		@(posedge clk) disable iff (!rstn)
		moe && !en && !run_off_sel |=> !main_oe;
	endproperty
	a_main_off: assert property (p_main_off) else $error("main output driven while disabled");

	property p_dead_gap;
		@(posedge clk) disable iff (!rstn)
		moe && en && comp_en && (ref_wave != prev_ref)
			|=> main_out == $past(out_pol) && comp_out == $past(comp_pol);
	endproperty
	a_dead_gap: assert property (p_dead_gap) else $error("output active without dead time");
endmodule

/* hw/ccen_top.sv */
// Channel enable and polarity register with per-channel output and capture control
//
// Summary of operation
// - Reset clears every enable and polarity bit to zero.
// - Bits 7..4 hold channel 2 enable, polarity, comp enable, comp polarity.
// - Bits 11..8 hold channel 3 enable, polarity, comp enable, comp polarity.
// - Channel 4 has only enable bit 12 and polarity bit 13.
// - Channel 5 has enable bit 16 and polarity bit 17.
// - Channel 6 has enable bit 20 and polarity bit 21.
// - Comp polarity 0 gives active-high comp output, 1 active-low.
// - Comp enable turns comp output on, subject to break and idle controls.
// - In output mode polarity 0 is active high, 1 active low.
// - In input mode polarity picks rising or falling edge and trigger inversion.
// - In output mode enable turns main output on, subject to break controls.
// - In input mode captures happen only while enable is set.
// - Main output only enabled with main output enable gives ref xor polarity.
// - Both outputs enabled give complementary outputs with polarity and dead time.
// - Direction select writes are ignored unless the channel enable is zero.
`timescale 1ns/1ps
module ccen_top (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESETN,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Compare reference waves and capture inputs
	input wire logic [5:0] COMPARE_REF_WAVE,
	input wire logic [5:0] CAPTURE_INPUT,
	// Main outputs
	output logic [5:0] MAIN_OUTPUT,
	output logic [5:0] MAIN_OE,
	// Complementary outputs
	output logic [2:0] COMP_OUTPUT,
	output logic [2:0] COMP_OE,
	// Capture side
	output logic [5:0] CAPTURE_EVENT,
	output logic [5:0] TRIGGER_OUT
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [31:0] channel_enable_polarity;
	logic [11:0] dir_select;
	logic [2:0] brk_ctl;
	logic [7:0] dead_time;
	logic [5:0] idle_main;
	logic [2:0] idle_comp;
	logic [5:0] cap_flag;
	logic [31:0] wmask;
	logic [31:0] rd_mux;
	logic req;
	logic wr;
	logic [5:0] in_mode;

	assign req = WB_CYC_I & WB_STB_I;
	// A write lands on the edge where the master sees ack
	assign wr = req & WB_WE_I & WB_ACK_O;
	assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

	// ----------------------------------------------------------------
	// Bus handshake: ack one cycle after the request, then drop
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			WB_ACK_O <= 1'b0;
		else
			WB_ACK_O <= req & ~WB_ACK_O;
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (WB_ADR_I)
			ccen_pkg::ADDR_CCEN: rd_mux = channel_enable_polarity & ccen_pkg::CCEN_MASK;
			ccen_pkg::ADDR_DIRSEL: rd_mux = {20'h00000, dir_select};
			ccen_pkg::ADDR_BRK: rd_mux = {16'h0000, dead_time, 5'h00, brk_ctl};
			ccen_pkg::ADDR_IDLE: rd_mux = {21'h000000, idle_comp, 2'h0, idle_main};
			ccen_pkg::ADDR_CAPST: rd_mux = {26'h0000000, cap_flag};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is latched with the ack, so it stays stable while ack is high
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			WB_DAT_O <= 32'h0000_0000;
		else if (req & ~WB_ACK_O)
			WB_DAT_O <= rd_mux;
	end

	// ----------------------------------------------------------------
	// Channel enable and polarity register
	// ----------------------------------------------------------------
	// Reserved bits are never stored, so they read zero whatever is written
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			channel_enable_polarity <= ccen_pkg::CCEN_RESET;
		else if (wr && WB_ADR_I == ccen_pkg::ADDR_CCEN)
			channel_enable_polarity <= ((channel_enable_polarity & ~wmask) | (WB_DAT_I & wmask))
				& ccen_pkg::CCEN_MASK;
	end

	// ----------------------------------------------------------------
	// Direction select, locked while the channel is enabled
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			dir_select <= ccen_pkg::DIRSEL_RESET;
		else if (wr && WB_ADR_I == ccen_pkg::ADDR_DIRSEL && WB_SEL_I[0])
		begin
			for (int i = 0; i < ccen_pkg::NUM_CH; i++)
				if (!channel_enable_polarity[ccen_pkg::OUT_EN_BIT[i]])
					dir_select[i*ccen_pkg::DIRSEL_W +: ccen_pkg::DIRSEL_W] <=
						WB_DAT_I[i*ccen_pkg::DIRSEL_W +: ccen_pkg::DIRSEL_W];
		end
	end

	// ----------------------------------------------------------------
	// Break, off-state and dead-time control
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			brk_ctl <= ccen_pkg::BRK_RESET;
			dead_time <= ccen_pkg::DT_RESET;
		end
		else if (wr && WB_ADR_I == ccen_pkg::ADDR_BRK)
		begin
			if (WB_SEL_I[0])
				brk_ctl <= WB_DAT_I[2:0];
			if (WB_SEL_I[1])
				dead_time <= WB_DAT_I[ccen_pkg::DT_LSB +: ccen_pkg::DT_W];
		end
	end

	// ----------------------------------------------------------------
	// Idle levels
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			idle_main <= ccen_pkg::IDLE_MAIN_RESET;
			idle_comp <= ccen_pkg::IDLE_COMP_RESET;
		end
		else if (wr && WB_ADR_I == ccen_pkg::ADDR_IDLE)
		begin
			if (WB_SEL_I[0])
				idle_main <= WB_DAT_I[5:0];
			if (WB_SEL_I[1])
				idle_comp <= WB_DAT_I[ccen_pkg::IDLE_COMP_LSB +: ccen_pkg::NUM_COMP];
		end
	end

	// ----------------------------------------------------------------
	// Capture flags: write one to clear, a new capture wins
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
			cap_flag <= 6'h00;
		else if (wr && WB_ADR_I == ccen_pkg::ADDR_CAPST && WB_SEL_I[0])
			cap_flag <= (cap_flag & ~WB_DAT_I[5:0]) | CAPTURE_EVENT;
		else
			cap_flag <= cap_flag | CAPTURE_EVENT;
	end

	// ----------------------------------------------------------------
	// Per-channel logic
	// ----------------------------------------------------------------
	for (genvar i = 0; i < ccen_pkg::NUM_CH; i++)
	begin : g_ch
		assign in_mode[i] = dir_select[i*ccen_pkg::DIRSEL_W +: ccen_pkg::DIRSEL_W] != ccen_pkg::DIR_OUTPUT;

		cap_edge u_cap (
			.clk(MCLK),
			.rstn(RESETN),
			.in_mode(in_mode[i]),
			.enable(channel_enable_polarity[ccen_pkg::OUT_EN_BIT[i]]),
			.polarity(channel_enable_polarity[ccen_pkg::OUT_POL_BIT[i]]),
			.cap_in(CAPTURE_INPUT[i]),
			.trig(TRIGGER_OUT[i]),
			.capture(CAPTURE_EVENT[i])
		);

		if (i < ccen_pkg::NUM_COMP)
		begin : g_pair
			out_stage u_out (
				.clk(MCLK),
				.rstn(RESETN),
				.out_mode(~in_mode[i]),
				.ref_wave(COMPARE_REF_WAVE[i]),
				.out_en(channel_enable_polarity[ccen_pkg::OUT_EN_BIT[i]]),
				.out_pol(channel_enable_polarity[ccen_pkg::OUT_POL_BIT[i]]),
				.comp_en(channel_enable_polarity[ccen_pkg::COMP_EN_BIT[i]]),
				.comp_pol(channel_enable_polarity[ccen_pkg::COMP_POL_BIT[i]]),
				.idle_main(idle_main[i]),
				.idle_comp(idle_comp[i]),
				.moe(brk_ctl[ccen_pkg::MOE_BIT]),
				.idle_off_sel(brk_ctl[ccen_pkg::IDLE_OFF_BIT]),
				.run_off_sel(brk_ctl[ccen_pkg::RUN_OFF_BIT]),
				.dead_time(dead_time),
				.main_out(MAIN_OUTPUT[i]),
				.main_oe(MAIN_OE[i]),
				.comp_out(COMP_OUTPUT[i]),
				.comp_oe(COMP_OE[i])
			);
		end
		else
		begin : g_single
			// Channels without a complementary pin keep it tied off
			out_stage u_out (
				.clk(MCLK),
				.rstn(RESETN),
				.out_mode(~in_mode[i]),
				.ref_wave(COMPARE_REF_WAVE[i]),
				.out_en(channel_enable_polarity[ccen_pkg::OUT_EN_BIT[i]]),
				.out_pol(channel_enable_polarity[ccen_pkg::OUT_POL_BIT[i]]),
				.comp_en(1'b0),
				.comp_pol(1'b0),
				.idle_main(idle_main[i]),
				.idle_comp(1'b0),
				.moe(brk_ctl[ccen_pkg::MOE_BIT]),
				.idle_off_sel(brk_ctl[ccen_pkg::IDLE_OFF_BIT]),
				.run_off_sel(brk_ctl[ccen_pkg::RUN_OFF_BIT]),
				.dead_time(dead_time),
				.main_out(MAIN_OUTPUT[i]),
				.main_oe(MAIN_OE[i]),
				.comp_out(),
				.comp_oe()
			);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_req;
		req && !WB_ACK_O;
	endsequence

	sequence s_ack_pulse;
		WB_ACK_O ##1 !WB_ACK_O;
	endsequence

	property p_bus_ack;
		@(posedge MCLK) disable iff (!RESETN)
		s_req |=> s_ack_pulse;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("ack not one cycle after request");

	property p_reset_zero;
		@(posedge MCLK) disable iff (!RESETN)
		!$past(RESETN) |-> channel_enable_polarity == 32'h0000_0000 && !WB_ACK_O;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("enable register not zero after reset");

	property p_wr_low;
		@(posedge MCLK) disable iff (!RESETN)
		wr && WB_ADR_I == ccen_pkg::ADDR_CCEN && WB_SEL_I[0]
			|=> channel_enable_polarity[7:0] == $past(WB_DAT_I[7:0]);
	endproperty
	a_wr_low: assert property (p_wr_low) else $error("channel 1-2 bits not written");

	property p_wr_ch34;
		@(posedge MCLK) disable iff (!RESETN)
		wr && WB_ADR_I == ccen_pkg::ADDR_CCEN && WB_SEL_I[1]
			|=> channel_enable_polarity[15:8] == {2'h0, $past(WB_DAT_I[13:8])};
	endproperty
	a_wr_ch34: assert property (p_wr_ch34) else $error("channel 3-4 bits wrong");

	property p_wr_ch56;
		@(posedge MCLK) disable iff (!RESETN)
		wr && WB_ADR_I == ccen_pkg::ADDR_CCEN && WB_SEL_I[2]
			|=> channel_enable_polarity[23:16] == {2'h0, $past(WB_DAT_I[21:20]), 2'h0, $past(WB_DAT_I[17:16])};
	endproperty
	a_wr_ch56: assert property (p_wr_ch56) else $error("channel 5-6 bits wrong");

	property p_readback;
		@(posedge MCLK) disable iff (!RESETN)
		WB_ACK_O && !WB_WE_I && WB_ADR_I == ccen_pkg::ADDR_CCEN
			|-> WB_DAT_O == (channel_enable_polarity & ccen_pkg::CCEN_MASK);
	endproperty
	a_readback: assert property (p_readback) else $error("read value differs from stored bits");

	property p_dir_lock;
		@(posedge MCLK) disable iff (!RESETN)
		wr && WB_ADR_I == ccen_pkg::ADDR_DIRSEL && channel_enable_polarity[0]
			|=> dir_select[1:0] == $past(dir_select[1:0]);
	endproperty
	a_dir_lock: assert property (p_dir_lock) else $error("direction changed while enabled");
endmodule

/* tb/timer_channel_enable_polarity_bench.sv */
// Self-checking bench for the channel enable and polarity block
`timescale 1ns/1ps
module timer_channel_enable_polarity_bench;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0000_0000;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic [5:0] ref_wave = 6'h00;
	logic [5:0] cap_in = 6'h00;
	logic [5:0] main_out;
	logic [5:0] main_oe;
	logic [2:0] comp_out;
	logic [2:0] comp_oe;
	logic [5:0] cap_event;
	logic [5:0] trig_out;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int ev_count = 0;
	logic [31:0] q;

	ccen_top u_ccen_top (
		.MCLK(mclk),
		.RESETN(resetn),
		.WB_CYC_I(wb_cyc),
		.WB_STB_I(wb_stb),
		.WB_WE_I(wb_we),
		.WB_ADR_I(wb_adr),
		.WB_SEL_I(wb_sel),
		.WB_DAT_I(wb_dat_w),
		.WB_DAT_O(wb_dat_r),
		.WB_ACK_O(wb_ack),
		.COMPARE_REF_WAVE(ref_wave),
		.CAPTURE_INPUT(cap_in),
		.MAIN_OUTPUT(main_out),
		.MAIN_OE(main_oe),
		.COMP_OUTPUT(comp_out),
		.COMP_OE(comp_oe),
		.CAPTURE_EVENT(cap_event),
		.TRIGGER_OUT(trig_out)
	);

	initial
	begin
		forever #2.5 mclk = ~mclk;
	end

	// Counts channel 1 capture pulses; sampled on every clock, so one-cycle pulses are not missed
	always @(posedge mclk)
	begin
		if (cap_event[0] === 1'b1)
			ev_count <= ev_count + 1;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// The run is a few hundred cycles; the ceiling leaves ample margin
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			summarize();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Classic single cycle; the wait is bounded only by the bench timeout
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat_w <= d;
		do
			@(posedge mclk);
		while (wb_ack !== 1'b1);
		r = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		bus(0, ccen_pkg::ADDR_CCEN, 32'h0, q);
		chk("ccen after reset", ccen_pkg::CCEN_RESET, q);
		// Reserved bits are always written as zero
		bus(1, ccen_pkg::ADDR_CCEN, 32'h0033_3fff, q);
		bus(0, ccen_pkg::ADDR_CCEN, 32'h0, q);
		chk("ccen all ones", 32'h0033_3fff, q);
		// Every channel with a polarity bit set has at least one enable set
		bus(1, ccen_pkg::ADDR_CCEN, 32'h0013_165d, q);
		bus(0, ccen_pkg::ADDR_CCEN, 32'h0, q);
		chk("ccen pattern", 32'h0013_165d, q);
		bus(1, 8'h10, 32'hffff_ffff, q);
		bus(0, 8'h10, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		bus(1, ccen_pkg::ADDR_CCEN, 32'h0, q);
		$display("test regs done");
	endtask

	// Main output only, run mode: pin follows reference xor polarity
	task automatic t_main();
		logic pol;
		bus(1, ccen_pkg::ADDR_BRK, 32'h1, q);
		for (int i = 0; i < 6; i++)
		begin
			for (int p = 0; p < 2; p++)
			begin
				pol = p[0];
				bus(1, ccen_pkg::ADDR_CCEN, (32'h1 << ccen_pkg::OUT_EN_BIT[i]) |
					(32'(pol) << ccen_pkg::OUT_POL_BIT[i]), q);
				for (int r = 0; r < 2; r++)
				begin
					@(posedge mclk);
					ref_wave <= {6{r[0]}};
					repeat (3) @(posedge mclk);
					chk("main out", 32'(r[0] ^ pol), 32'(main_out[i]));
					chk("main oe", 32'h1, 32'(main_oe[i]));
				end
			end
		end
		$display("test main done");
	endtask

	// Complementary only, run mode: comp pin follows reference xor comp polarity
	task automatic t_comp();
		logic pol;
		for (int i = 0; i < 3; i++)
		begin
			for (int p = 0; p < 2; p++)
			begin
				pol = p[0];
				bus(1, ccen_pkg::ADDR_CCEN, (32'h1 << ccen_pkg::COMP_EN_BIT[i]) |
					(32'(pol) << ccen_pkg::COMP_POL_BIT[i]), q);
				for (int r = 0; r < 2; r++)
				begin
					@(posedge mclk);
					ref_wave <= {6{r[0]}};
					repeat (3) @(posedge mclk);
					chk("comp out", 32'(r[0] ^ pol), 32'(comp_out[i]));
					chk("comp oe", 32'h1, 32'(comp_oe[i]));
					chk("main oe off", 32'h0, 32'(main_oe[i]));
				end
			end
		end
		$display("test comp done");
	endtask

	task automatic edge_in(input logic v);
		@(posedge mclk);
		cap_in[0] <= v;
		repeat (4) @(posedge mclk);
	endtask

	task automatic t_capture();
		int base;
		bus(1, ccen_pkg::ADDR_DIRSEL, 32'h1, q);
		base = ev_count;
		edge_in(1'b1);
		chk("events while disabled", 32'h0, 32'(ev_count - base));
		edge_in(1'b0);
		bus(1, ccen_pkg::ADDR_CCEN, 32'h1, q);
		repeat (3) @(posedge mclk);
		base = ev_count;
		edge_in(1'b1);
		chk("trigger rising", 32'h1, 32'(trig_out[0]));
		edge_in(1'b0);
		chk("rising events", 32'h1, 32'(ev_count - base));
		bus(1, ccen_pkg::ADDR_CCEN, 32'h3, q);
		repeat (3) @(posedge mclk);
		chk("trigger inverted", 32'h1, 32'(trig_out[0]));
		base = ev_count;
		edge_in(1'b1);
		edge_in(1'b0);
		chk("falling events", 32'h1, 32'(ev_count - base));
		bus(0, ccen_pkg::ADDR_CAPST, 32'h0, q);
		chk("capture flag", 32'h1, q);
		bus(1, ccen_pkg::ADDR_CAPST, 32'h0000_003f, q);
		bus(0, ccen_pkg::ADDR_CAPST, 32'h0, q);
		chk("flag cleared", 32'h0, q);
		bus(1, ccen_pkg::ADDR_DIRSEL, 32'h0, q);
		bus(0, ccen_pkg::ADDR_DIRSEL, 32'h0, q);
		chk("dirsel locked", 32'h1, q & 32'h3);
		bus(1, ccen_pkg::ADDR_CCEN, 32'h0, q);
		bus(1, ccen_pkg::ADDR_DIRSEL, 32'h0, q);
		bus(0, ccen_pkg::ADDR_DIRSEL, 32'h0, q);
		chk("dirsel free", 32'h0, q & 32'h3);
		$display("test capture done");
	endtask

	// Channel 1 pair with four cycles of dead time, then the off states
	task automatic t_pair();
		@(posedge mclk);
		ref_wave <= 6'h00;
		bus(1, ccen_pkg::ADDR_BRK, 32'h0000_0401, q);
		bus(1, ccen_pkg::ADDR_CCEN, 32'h0000_0005, q);
		repeat (8) @(posedge mclk);
		for (int r = 1; r >= 0; r--)
		begin
			@(posedge mclk);
			ref_wave <= {6{r[0]}};
			repeat (2) @(posedge mclk);
			chk("dead main", 32'h0, 32'(main_out[0]));
			chk("dead comp", 32'h0, 32'(comp_out[0]));
			repeat (6) @(posedge mclk);
			chk("pair main", 32'(r[0]), 32'(main_out[0]));
			chk("pair comp", 32'(!r[0]), 32'(comp_out[0]));
			chk("pair oe", 32'h3, {30'h0, main_oe[0], comp_oe[0]});
		end
		bus(1, ccen_pkg::ADDR_CCEN, 32'h0000_0006, q);
		bus(1, ccen_pkg::ADDR_BRK, 32'h0000_0005, q);
		repeat (2) @(posedge mclk);
		chk("run off main", 32'h3, {30'h0, main_out[0], main_oe[0]});
		bus(1, ccen_pkg::ADDR_IDLE, 32'h0000_0100, q);
		bus(1, ccen_pkg::ADDR_BRK, 32'h0000_0002, q);
		repeat (2) @(posedge mclk);
		chk("idle main", 32'h1, {30'h0, main_out[0], main_oe[0]});
		chk("idle comp", 32'h3, {30'h0, comp_out[0], comp_oe[0]});
		bus(1, ccen_pkg::ADDR_BRK, 32'h0, q);
		repeat (2) @(posedge mclk);
		chk("off oe", 32'h0, {30'h0, main_oe[0], comp_oe[0]});
		// Idle levels go before the enables so no unused channel keeps them
		bus(1, ccen_pkg::ADDR_IDLE, 32'h0, q);
		bus(1, ccen_pkg::ADDR_CCEN, 32'h0, q);
		$display("test pair done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		t_regs();
		t_main();
		t_comp();
		t_capture();
		t_pair();
		summarize();
	end
endmodule
